// *** shared/clar_regs.vh ***
// register map, field values and timing constants of the limit and alert reporter
`ifndef CLAR_REGS_VH
`define CLAR_REGS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CLAR_OFF_CMD      12'h000
`define CLAR_OFF_LIMIT    12'h004
`define CLAR_OFF_CONFIG   12'h008
`define CLAR_OFF_STATUS   12'h00c
`define CLAR_OFF_ALERT    12'h010
`define CLAR_OFF_SCANCFG  12'h014
`define CLAR_OFF_EVENT    12'h018
`define CLAR_OFF_DEVLIM   12'h01c
// ----------------------------------------------------------------
// command codes written to the command register
// ----------------------------------------------------------------
`define CLAR_CMD_RESET    4'h1
`define CLAR_CMD_SCAN_EN  4'h2
`define CLAR_CMD_SCAN_DIS 4'h3
`define CLAR_CMD_DEV_DIS  4'h4
`define CLAR_CMD_TIMETEMP 4'h5
`define CLAR_CMD_BAD      4'h6
`define CLAR_CMD_CLEARKEY 4'h7
// ----------------------------------------------------------------
// limits, in tenths of a degree, 16-bit two's complement
// ----------------------------------------------------------------
`define CLAR_LIMIT_MIN    16'hfc18
`define CLAR_PROBE_MAX    16'h0c4e
// ----------------------------------------------------------------
// config fields and status bytes
// ----------------------------------------------------------------
`define CLAR_CFG_PROBE_LO 3'h1
`define CLAR_CFG_PROBE_HI 3'h7
`define CLAR_CFG_RESET    32'h0000_0001
`define CLAR_STB_TIMEOUT  8'h41
`define CLAR_STB_IDLE     8'h00
// ----------------------------------------------------------------
// alert characters
// ----------------------------------------------------------------
`define CLAR_CH_CMD_ERR   8'h42
`define CLAR_CH_SOAK      8'h43
`define CLAR_CH_CYCLE     8'h44
`define CLAR_CH_RUN       8'h45
`define CLAR_CH_DEV       8'h46
`define CLAR_CH_OVER      8'h47
`define CLAR_CH_BUS_LOCK  8'h4f
// ----------------------------------------------------------------
// bus address characters and scan sizes
// ----------------------------------------------------------------
`define CLAR_TALK_BASE    8'h40
`define CLAR_LISTEN_BASE  8'h20
`define CLAR_MAX_SEGS     4'ha
`define CLAR_MAX_CYCLES   11'h708
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLAR_CLK_MHZ      100
`define CLAR_ADDR_SHOW_S  3
`define CLAR_PREWARN_S    60
`endif

// *** rtl/clar_reporter.v ***
// limit setting, persistent config, time-out and problem alert reporter
// Functional notes
// - accept a new upper limit only within -100 to probe maximum inclusive
// - probe maximum is a constant 315 degrees
// - upper limit loads the probe maximum at power up
// - limit query returns the currently held upper limit
// - config only from remote interface; stored to nonvolatile memory
// - first config field is probe code 1 to 7
// - config fields: probe, P, I, D, time unit letter M or H
// - single-mode soak time-out lights lamp, sounds tone, requests service
// - serial poll after single time-out answers 0x41
// - serial poll without time-out answers 0x00
// - lamp and tone hold until bus reset or unlocked clear key
// - setting or reading time or temperature clears lamp and tone
// - scan indications off after reset; only enable/disable commands change them
// - scan holds at most 10 segments of temperature and soak time
// - scan repeats for a programmed count up to 1800
// - enabled scan alerts: 0x43 segment, 0x44 cycle, 0x45 run end
// - each scan alert goes out one minute before its time-out
// - 0x46 on deviation when enabled; 0x47 when chamber exceeds upper limit
// - 0x42 on bad command; 0x4f on bus lock-up time-out
// - address from four switches; switch on is 0, off is 1
// - show address three seconds after power up and after reset command
// - sixteen addresses; talk 0x40 plus, listen 0x20 plus address
// - writing a deviation limit enables deviation reporting; disable command clears
// - scan enable command permits soak characters; disable suppresses them
`timescale 1ns/100ps
`default_nettype none
`include "clar_regs.vh"
module clar_reporter #(
  parameter integer SHOW_CYCLES    = `CLAR_ADDR_SHOW_S * `CLAR_CLK_MHZ * 1000000,
  parameter [35:0]  PREWARN_CYCLES = 36'd1 * `CLAR_PREWARN_S * `CLAR_CLK_MHZ * 1000000
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // events from the servo, scan sequencer and bus engine
  input  wire        soak_done_single,
  input  wire        scan_seg_due,
  input  wire        scan_cycle_due,
  input  wire        scan_run_due,
  input  wire        dev_exceeded,
  input  wire        bus_lockup,
  input  wire [15:0] chamber_temp,
  // front panel
  input  wire [3:0]  addr_switch_n,
  input  wire        local_lockout,
  output reg         timeout_lamp,
  output reg         tone_on,
  output reg         addr_show,
  // instrument bus side
  output reg         srq,
  output reg  [7:0]  poll_status,
  output reg  [7:0]  talk_char,
  output reg  [7:0]  listen_char,
  output reg  [7:0]  alert_char,
  output reg         alert_valid,
  input  wire        alert_ready,
  // nonvolatile store
  output reg  [31:0] nv_data,
  output reg         nv_write
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function in_limit;
    input [15:0] v;
    begin
      in_limit = ($signed(v) >= $signed(`CLAR_LIMIT_MIN)) &&
                 ($signed(v) <= $signed(`CLAR_PROBE_MAX));
    end
  endfunction

  function cfg_ok;
    input [31:0] c;
    begin
      // probe[2:0], p[7:4], i[11:8], d[15:12], unit[16] 0=M 1=H
      cfg_ok = (c[2:0] >= `CLAR_CFG_PROBE_LO) && (c[2:0] <= `CLAR_CFG_PROBE_HI);
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers for pins
  // ----------------------------------------------------------------
  reg [3:0] sw_s1_q, sw_s2_q;
  reg       lock_s1_q, lock_s2_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_s1_q   <= 4'h0;
      sw_s2_q   <= 4'h0;
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else begin
      sw_s1_q   <= addr_switch_n;
      sw_s2_q   <= sw_s1_q;
      lock_s1_q <= local_lockout;
      lock_s2_q <= lock_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire       acc   = psel && penable && !pready;
  wire       wr    = acc && pwrite;
  wire       rd    = acc && !pwrite;
  wire       hit   = (paddr == `CLAR_OFF_CMD)     || (paddr == `CLAR_OFF_LIMIT) ||
                     (paddr == `CLAR_OFF_CONFIG)  || (paddr == `CLAR_OFF_STATUS) ||
                     (paddr == `CLAR_OFF_ALERT)   || (paddr == `CLAR_OFF_SCANCFG) ||
                     (paddr == `CLAR_OFF_EVENT)   || (paddr == `CLAR_OFF_DEVLIM);
  wire [3:0] cmd   = pwdata[3:0];
  wire       cmd_w = wr && (paddr == `CLAR_OFF_CMD);
  wire       c_rst = cmd_w && (cmd == `CLAR_CMD_RESET);
  wire       c_tt  = cmd_w && (cmd == `CLAR_CMD_TIMETEMP);
  wire       c_key = cmd_w && (cmd == `CLAR_CMD_CLEARKEY);
  wire       c_bad = cmd_w && ((cmd == `CLAR_CMD_BAD) || (cmd == 4'h0) || (cmd > 4'h7));
  wire       lim_w = wr && (paddr == `CLAR_OFF_LIMIT);
  wire       cfg_w = wr && (paddr == `CLAR_OFF_CONFIG);
  wire       scn_w = wr && (paddr == `CLAR_OFF_SCANCFG);
  wire       dev_w = wr && (paddr == `CLAR_OFF_DEVLIM);
  wire       lim_bad = lim_w && !in_limit(pwdata[15:0]);
  wire       cfg_bad = cfg_w && !cfg_ok(pwdata);
  wire       scn_bad = scn_w && ((pwdata[3:0] > `CLAR_MAX_SEGS) ||
                                 (pwdata[26:16] > `CLAR_MAX_CYCLES));

  // ----------------------------------------------------------------
  // held settings
  // ----------------------------------------------------------------
  reg [15:0] limit_q;
  reg [31:0] config_q;
  reg        scan_en_q, dev_en_q;
  reg [15:0] dev_limit_q;
  reg [3:0]  seg_count_q;
  reg [10:0] cycle_count_q;
  reg        alarm_q, was_over_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_q       <= `CLAR_PROBE_MAX;
      config_q      <= `CLAR_CFG_RESET;
      scan_en_q     <= 1'b0;
      dev_en_q      <= 1'b0;
      dev_limit_q   <= 16'h0000;
      seg_count_q   <= 4'h0;
      cycle_count_q <= 11'h000;
      alarm_q       <= 1'b0;
      was_over_q    <= 1'b0;
    end else begin
      if (lim_w && in_limit(pwdata[15:0]))
        limit_q <= pwdata[15:0];
      if (cfg_w && cfg_ok(pwdata))
        config_q <= pwdata;
      if (c_rst)
        scan_en_q <= 1'b0;
      else if (cmd_w && (cmd == `CLAR_CMD_SCAN_EN))
        scan_en_q <= 1'b1;
      else if (cmd_w && (cmd == `CLAR_CMD_SCAN_DIS))
        scan_en_q <= 1'b0;
      if (dev_w) begin
        dev_limit_q <= pwdata[15:0];
        dev_en_q    <= 1'b1;
      end else if (c_rst || (cmd_w && (cmd == `CLAR_CMD_DEV_DIS)))
        dev_en_q <= 1'b0;
      if (scn_w && !scn_bad) begin
        seg_count_q   <= pwdata[3:0];
        cycle_count_q <= pwdata[26:16];
      end
      // set wins over any clear in the same cycle
      if (soak_done_single)
        alarm_q <= 1'b1;
      else if (c_rst || c_tt || (c_key && !lock_s2_q))
        alarm_q <= 1'b0;
      was_over_q <= $signed(chamber_temp) > $signed(limit_q);
    end
  end

  // ----------------------------------------------------------------
  // scan prewarning: due strobes are delayed-free; the sequencer
  // raises them one minute early, this block counts that window
  // ----------------------------------------------------------------
  reg [35:0] prewarn_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prewarn_q <= 36'h0;
    else if (scan_en_q && (scan_seg_due || scan_cycle_due || scan_run_due))
      prewarn_q <= PREWARN_CYCLES;
    else if (prewarn_q != 36'h0)
      prewarn_q <= prewarn_q - 36'h1;
  end

  // ----------------------------------------------------------------
  // alert queue, one character per source, lowest pending source index sent first
  // ----------------------------------------------------------------
  wire over_rise = ($signed(chamber_temp) > $signed(limit_q)) && !was_over_q;
  wire [6:0] raise;
  assign raise[0] = c_bad || lim_bad || cfg_bad || scn_bad;
  assign raise[1] = scan_en_q && scan_seg_due;
  assign raise[2] = scan_en_q && scan_cycle_due;
  assign raise[3] = scan_en_q && scan_run_due;
  assign raise[4] = dev_en_q && dev_exceeded;
  assign raise[5] = over_rise;
  assign raise[6] = bus_lockup;

  function [7:0] ch_of;
    input [2:0] i;
    begin
      case (i)
        3'd0:    ch_of = `CLAR_CH_CMD_ERR;
        3'd1:    ch_of = `CLAR_CH_SOAK;
        3'd2:    ch_of = `CLAR_CH_CYCLE;
        3'd3:    ch_of = `CLAR_CH_RUN;
        3'd4:    ch_of = `CLAR_CH_DEV;
        3'd5:    ch_of = `CLAR_CH_OVER;
        default: ch_of = `CLAR_CH_BUS_LOCK;
      endcase
    end
  endfunction

  // pending bits; a source raised while pending is merged, not lost
  reg [6:0] pend_q;
  reg [2:0] pick;
  reg       any;
  integer   k;
  always @* begin
    pick = 3'd0;
    any  = 1'b0;
    for (k = 6; k >= 0; k = k - 1)
      if (pend_q[k]) begin
        pick = k[2:0];
        any  = 1'b1;
      end
  end

  wire send_done = alert_valid && alert_ready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q      <= 7'h00;
      alert_valid <= 1'b0;
      alert_char  <= 8'h00;
    end else begin
      if (!alert_valid && any) begin
        pend_q      <= (pend_q & ~(7'h01 << pick)) | raise;
        alert_valid <= 1'b1;
        alert_char  <= ch_of(pick);
      end else begin
        pend_q <= pend_q | raise;
        if (send_done)
          alert_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // address display timer and outputs
  // ----------------------------------------------------------------
  reg [31:0] show_q;
  reg        stored_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      show_q       <= SHOW_CYCLES[31:0];
      addr_show    <= 1'b1;
      talk_char    <= `CLAR_TALK_BASE;
      listen_char  <= `CLAR_LISTEN_BASE;
      timeout_lamp <= 1'b0;
      tone_on      <= 1'b0;
      srq          <= 1'b0;
      poll_status  <= `CLAR_STB_IDLE;
      nv_data      <= `CLAR_CFG_RESET;
      nv_write     <= 1'b0;
      stored_q     <= 1'b0;
    end else begin
      if (c_rst)
        show_q <= SHOW_CYCLES[31:0];
      else if (show_q != 32'h0)
        show_q <= show_q - 32'h1;
      addr_show    <= c_rst || (show_q > 32'h1);
      talk_char    <= `CLAR_TALK_BASE + {4'h0, sw_s2_q};
      listen_char  <= `CLAR_LISTEN_BASE + {4'h0, sw_s2_q};
      timeout_lamp <= alarm_q;
      tone_on      <= alarm_q;
      srq          <= alarm_q;
      poll_status  <= alarm_q ? `CLAR_STB_TIMEOUT : `CLAR_STB_IDLE;
      nv_write     <= cfg_w && cfg_ok(pwdata);
      if (cfg_w && cfg_ok(pwdata))
        nv_data <= pwdata;
      stored_q <= stored_q | nv_write;
    end
  end

  // ----------------------------------------------------------------
  // apb answer: one wait state, unmapped or rejected limit, config or scan write gives pslverr; bad command does not
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc;
      pslverr <= acc && (!hit || lim_bad || cfg_bad || scn_bad);
      prdata  <= 32'h0;
      if (rd) begin
        case (paddr)
          `CLAR_OFF_LIMIT:   prdata <= {16'h0, limit_q};
          `CLAR_OFF_CONFIG:  prdata <= config_q;
          `CLAR_OFF_STATUS:  prdata <= {20'h0, stored_q, prewarn_q != 36'h0, dev_en_q,
                                        scan_en_q, poll_status};
          `CLAR_OFF_ALERT:   prdata <= {24'h0, alert_char};
          `CLAR_OFF_SCANCFG: prdata <= {5'h0, cycle_count_q, 12'h0, seg_count_q};
          `CLAR_OFF_EVENT:   prdata <= {25'h0, pend_q};
          `CLAR_OFF_DEVLIM:  prdata <= {16'h0, dev_limit_q};
          default:           prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule // clar_reporter
`default_nettype wire

// *** tb/clar_reporter_properties.sv ***
// assertion checker on the ports of the limit and alert reporter
`timescale 1ns/100ps
`default_nettype none
module clar_reporter_props #(
  parameter integer SHOW_CYCLES = 20
) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // events and panel
  input wire logic        soak_done_single,
  input wire logic        bus_lockup,
  input wire logic [3:0]  addr_switch_n,
  input wire logic        timeout_lamp,
  input wire logic        tone_on,
  input wire logic        srq,
  input wire logic        addr_show,
  input wire logic [7:0]  poll_status,
  input wire logic [7:0]  talk_char,
  input wire logic [7:0]  listen_char,
  // alert link and store
  input wire logic [7:0]  alert_char,
  input wire logic        alert_valid,
  input wire logic        alert_ready,
  input wire logic        nv_write
);
  // ----------------------------------------
  // age since reset release
  // ----------------------------------------
  // saturates so the display check does not fire again after a wrap
  logic [7:0] age_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 8'h00;
    end else if (age_q != 8'hff) begin
      age_q <= age_q + 8'h01;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag outside ready");
  a_alarm_set: assert property (soak_done_single |-> ##2 (timeout_lamp && tone_on && srq))
    else $error("soak time-out not shown");
  a_poll_byte: assert property (poll_status == (timeout_lamp ? 8'h41 : 8'h00))
    else $error("poll byte disagrees with alarm");
  a_addr_chars: assert property (
    age_q > 8'h07 && $stable(addr_switch_n) && addr_switch_n == $past(addr_switch_n, 2)
    && addr_switch_n == $past(addr_switch_n, 3) && addr_switch_n == $past(addr_switch_n, 4)
    |-> talk_char == {4'h4, addr_switch_n} && listen_char == {4'h2, addr_switch_n})
    else $error("address characters disagree with switches");
  a_show_hold: assert property (age_q < SHOW_CYCLES - 2 |-> addr_show)
    else $error("address display ended early");
  a_alert_hold: assert property (alert_valid && !alert_ready |=> alert_valid && $stable(alert_char))
    else $error("alert character dropped before taken");
  a_lockup_char: assert property (bus_lockup |-> ##[1:60] (alert_valid && alert_char == 8'h4f))
    else $error("lock-up character not sent");
  a_nv_cause: assert property (nv_write |->
    $past(psel && penable && pwrite && !pready && paddr == 12'h008)
    || $past(psel && penable && pwrite && !pready && paddr == 12'h008, 2))
    else $error("store written without config access");
endmodule // clar_reporter_props
bind clar_reporter clar_reporter_props #(.SHOW_CYCLES(SHOW_CYCLES)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .soak_done_single,
  .bus_lockup, .addr_switch_n, .timeout_lamp, .tone_on, .srq, .addr_show, .poll_status,
  .talk_char, .listen_char, .alert_char, .alert_valid, .alert_ready, .nv_write);
`default_nettype wire

// *** tb/clar_host_model.sv ***
// remote host that takes alert characters, promptly or slowly
`timescale 1ns/100ps
`default_nettype none
module clar_host_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // alert link
  input  wire logic       alert_valid,
  input  wire logic [7:0] alert_char,
  output var  logic       alert_ready,
  // control and capture
  input  wire logic       slow,
  output var  logic       rx_stb,
  output var  logic [7:0] rx_char
);
  logic [1:0] gap_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 2'h0;
      alert_ready <= 1'b0;
      rx_stb <= 1'b0;
      rx_char <= 8'h00;
    end else begin
      gap_q <= gap_q + 2'h1;
      // a slow host listens one cycle in four, so the queue must hold
      alert_ready <= !slow || gap_q == 2'h3;
      rx_stb <= alert_valid && alert_ready;
      rx_char <= alert_char;
    end
  end
endmodule // clar_host_model
`default_nettype wire

// *** tb/clar_reporter_test.sv ***
// self-checking bench for the limit and alert reporter
`timescale 1ns/100ps
`default_nettype none
module clar_reporter_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, soak_done_single, scan_seg_due;
  logic scan_cycle_due, scan_run_due, dev_exceeded, bus_lockup, local_lockout, timeout_lamp;
  logic tone_on, addr_show, srq, alert_valid, alert_ready, nv_write, slow, rx_stb;
  logic [3:0]  addr_switch_n, sw;
  logic [5:0]  ev;
  logic [7:0]  poll_status, talk_char, listen_char, alert_char, rx_char;
  logic [11:0] paddr;
  logic [15:0] chamber_temp;
  logic [31:0] pwdata, prdata, nv_data, rdv, cw;
  logic [7:0]  exp_q[$], got_q[$];
  int          fails, check_count, nv_cnt;
  assign {soak_done_single, scan_seg_due, scan_cycle_due, scan_run_due, dev_exceeded,
          bus_lockup} = ev;
  clar_reporter #(.SHOW_CYCLES(20), .PREWARN_CYCLES(50)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .soak_done_single, .scan_seg_due, .scan_cycle_due, .scan_run_due, .dev_exceeded,
    .bus_lockup, .chamber_temp, .addr_switch_n, .local_lockout, .timeout_lamp, .tone_on,
    .addr_show, .srq, .poll_status, .talk_char, .listen_char, .alert_char, .alert_valid,
    .alert_ready, .nv_data, .nv_write);
  clar_host_model host (.pclk, .presetn, .alert_valid, .alert_char, .alert_ready, .slow,
    .rx_stb, .rx_char);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (rx_stb === 1'b1) got_q.push_back(rx_char);
    if (nv_write === 1'b1) nv_cnt++;
  end
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    chk({30'h0, pready, pslverr}, {30'h1, e}, "ready/err");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rdv & 32'hffff, e, "read");
  endtask
  task cmd(input logic [3:0] c);
    apb(1'b1, 12'h000, {28'h0, c}, 1'b0);
  endtask
  task fire(input logic [5:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 6'h00;
  endtask
  task alarm(input logic on);
    repeat (3) @(posedge pclk);
    chk({29'h0, timeout_lamp, tone_on, srq}, {29'h0, {3{on}}}, "alarm");
    chk({24'h0, poll_status}, on ? 32'h41 : 32'h0, "poll");
  endtask
  task flush;
    repeat (60) @(posedge pclk);
    chk(got_q.size(), exp_q.size(), "alert count");
    foreach (exp_q[i]) if (i < got_q.size()) chk({24'h0, got_q[i]}, {24'h0, exp_q[i]}, "alert");
    exp_q.delete();
    got_q.delete();
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge pclk);
    fails++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev, local_lockout, slow} = '0;
    chamber_temp = 16'h0100;
    addr_switch_n = 4'ha;
    {fails, check_count, nv_cnt} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, addr_show}, 32'h1, "show");
    for (int s = 0; s < 16; s += 5) begin
      addr_switch_n <= s[3:0];
      sw = s[3:0];
      repeat (5) @(posedge pclk);
      chk({talk_char, listen_char}, {4'h4, sw, 4'h2, sw}, "addr");
    end
    chk({31'h0, addr_show}, 32'h0, "show off");
    rd(12'h004, 32'h0c4e);
    apb(1'b1, 12'h004, 32'hffff_fc18, 1'b0);
    rd(12'h004, 32'hfc18);
    apb(1'b1, 12'h004, 32'hffff_fc17, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0c4f, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0c4e, 1'b0);
    rd(12'h004, 32'h0c4e);
    apb(1'b1, 12'h008, 32'h0000_3210, 1'b1);
    exp_q = '{8'h47, 8'h42, 8'h42, 8'h42};
    for (int p = 1; p < 8; p++) begin
      cw = {15'h0, p[0], 12'h321, 1'b0, p[2:0]};
      apb(1'b1, 12'h008, cw, 1'b0);
      repeat (2) @(posedge pclk);
      chk(nv_data, cw, "store");
    end
    chk(nv_cnt, 32'd7, "store count");
    rd(12'h008, 32'h3217);
    flush();
    fire(6'h20);
    alarm(1'b1);
    local_lockout <= 1'b1;
    repeat (4) @(posedge pclk);
    cmd(4'h7);
    alarm(1'b1);
    local_lockout <= 1'b0;
    repeat (4) @(posedge pclk);
    cmd(4'h7);
    alarm(1'b0);
    fire(6'h20);
    cmd(4'h5);
    alarm(1'b0);
    fire(6'h20);
    cmd(4'h1);
    alarm(1'b0);
    chk({31'h0, addr_show}, 32'h1, "show again");
    fire(6'h1e);
    flush();
    cmd(4'h2);
    slow <= 1'b1;
    fire(6'h1c);
    exp_q = '{8'h43, 8'h44, 8'h45};
    flush();
    apb(1'b1, 12'h01c, 32'h64, 1'b0);
    fire(6'h03);
    exp_q = '{8'h46, 8'h4f};
    flush();
    slow <= 1'b0;
    apb(1'b1, 12'h014, 32'h0708_000a, 1'b0);
    apb(1'b0, 12'h014, 32'h0, 1'b0);
    chk(rdv, 32'h0708_000a, "scan cfg");
    apb(1'b1, 12'h014, 32'h0709_000a, 1'b1);
    apb(1'b1, 12'h014, 32'h0708_000b, 1'b1);
    cmd(4'h3);
    cmd(4'h4);
    cmd(4'h6);
    fire(6'h12);
    exp_q = '{8'h42, 8'h42, 8'h42};
    flush();
    chamber_temp <= 16'h0c80;
    exp_q = '{8'h47};
    flush();
    apb(1'b0, 12'h020, 32'h0, 1'b1);
    summarize();
  end
endmodule // clar_reporter_test
`default_nettype wire
